// file: rtl/adc_device_end.sv
// converter end: conversion start, mode pick and serial readout
// assumes link pins come from another domain and are resynchronised
module adc_device_end (
	// system
	input wire logic clk_sys,
	input wire logic resetn,
	// serial link
	adc_link_if.device link,
	// digital stand-in for the sampled input
	input wire logic [15:0] sample_value,
	input wire logic over_range,
	input wire logic under_range,
	// conversion length in system cycles, clamped to the window
	input wire logic [15:0] conv_cycles,
	// status
	output logic converting,
	output logic low_power,
	output logic chain_mode,
	output logic busy_enabled,
	output logic [15:0] result
);

	// =====================================================
	// pin synchronisers
	logic [2:0] pin_meta_q; // first stage, read only by second
	logic [2:0] pin_sync_q; // {clock, data-in, convert}
	logic [2:0] pin_prev_q; // one cycle older, for edges

	// two flops on every pin before any logic looks at it
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			pin_prev_q <= 3'h0;
		end else begin
			pin_meta_q <= {link.serial_clock, link.serial_data_in_select, link.convert_start};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	logic cnv_s; // synced convert
	logic sdi_s; // synced data-in
	logic sck_s; // synced serial clock
	logic cnv_rise; // convert rising edge seen
	logic cnv_fall; // convert falling edge seen
	logic sck_fall; // serial clock falling edge seen
	logic select_on; // read selected: either select line low
	logic select_rise; // both select lines back high

	assign cnv_s = pin_sync_q[0];
	assign sdi_s = pin_sync_q[1];
	assign sck_s = pin_sync_q[2];
	assign cnv_rise = cnv_s & ~pin_prev_q[0];
	assign cnv_fall = ~cnv_s & pin_prev_q[0];
	assign sck_fall = ~sck_s & pin_prev_q[2];
	// three-wire holds data-in high, four-wire holds convert high
	assign select_on = ~(cnv_s & sdi_s);
	assign select_rise = cnv_s & sdi_s & ~(pin_prev_q[0] & pin_prev_q[1]);

	// =====================================================
	// sample code and conversion length
	logic [15:0] code_in; // clamped two's-complement code
	logic [15:0] conv_len; // clamped conversion length

	// saturate out-of-range inputs to the end codes
	always_comb begin
		if (over_range) begin
			code_in = adc_link_pkg::CODE_POS_FULL;
		end else if (under_range) begin
			code_in = adc_link_pkg::CODE_NEG_FULL;
		end else begin
			code_in = sample_value;
		end
	end

	// keep the length inside the documented window so hosts can be stressed
	always_comb begin
		if (conv_cycles < adc_link_pkg::CONV_MIN_C16) begin
			conv_len = adc_link_pkg::CONV_MIN_C16;
		end else if (conv_cycles > adc_link_pkg::CONV_MAX_C16) begin
			conv_len = adc_link_pkg::CONV_MAX_C16;
		end else begin
			conv_len = conv_cycles;
		end
	end

	// =====================================================
	// control state
	adc_link_pkg::dev_state_t state_q; // phase of the converter
	logic chain_q; // chain mode picked at last start
	logic chain_busy_q; // clock level at start, chain busy choice
	logic busy_q; // start bit leads this readout
	logic [15:0] held_q; // code captured at the sampling edge
	logic [15:0] result_q; // finished conversion result
	logic [15:0] cnt_q; // conversion cycle counter
	logic [16:0] shift_q; // output shift path, start bit in top
	logic [4:0] falls_q; // falling clock edges in this readout
	logic oe_q; // driving the result line
	logic conv_done; // last conversion cycle
	logic cs_busy; // chip-select busy decision at the end
	logic read_last; // last bit of a chip-select readout

	assign conv_done = (state_q == adc_link_pkg::DEV_CONV) && (cnt_q >= conv_len);
	assign cs_busy = ~cnv_s | ~sdi_s;
	assign read_last = sck_fall && !chain_q &&
		(falls_q == (busy_q ? 5'(adc_link_pkg::START_BITS - 1)
			: 5'(adc_link_pkg::RESULT_BITS - 1)));

	// phase sequencing
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= adc_link_pkg::DEV_ACQ;
		end else begin
			case (state_q)
				adc_link_pkg::DEV_ACQ: begin
					// acquiring and powered down until a start edge
					if (cnv_rise) begin
						state_q <= adc_link_pkg::DEV_CONV;
					end
				end
				adc_link_pkg::DEV_CONV: begin
					// convert edges are ignored until the count runs out
					if (conv_done) begin
						if (chain_q || cs_busy) begin
							state_q <= adc_link_pkg::DEV_SHIFT;
						end else begin
							state_q <= adc_link_pkg::DEV_WAIT;
						end
					end
				end
				adc_link_pkg::DEV_WAIT: begin
					// result waits for a select or is lost to a new start
					if (cnv_rise) begin
						state_q <= adc_link_pkg::DEV_CONV;
					end else if (select_on) begin
						state_q <= adc_link_pkg::DEV_SHIFT;
					end
				end
				adc_link_pkg::DEV_SHIFT: begin
					if (cnv_rise) begin
						state_q <= adc_link_pkg::DEV_CONV;
					end else if (chain_q && cnv_fall) begin
						state_q <= adc_link_pkg::DEV_ACQ;
					end else if (!chain_q && (select_rise || read_last)) begin
						state_q <= adc_link_pkg::DEV_ACQ;
					end
				end
				default: begin
					state_q <= adc_link_pkg::DEV_ACQ;
				end
			endcase
		end
	end

	// mode pick at the start edge; data-in is taken one cycle before the
	// edge so a data-in tied to convert still reads low
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			chain_q <= 1'b0;
			chain_busy_q <= 1'b0;
			held_q <= 16'h0000;
		end else if (cnv_rise && (state_q != adc_link_pkg::DEV_CONV)) begin
			chain_q <= ~pin_prev_q[1];
			chain_busy_q <= pin_prev_q[2];
			held_q <= code_in;
		end
	end

	// conversion counter on the internal clock, serial clock unused
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cnt_q <= 16'h0000;
		end else if (state_q != adc_link_pkg::DEV_CONV) begin
			cnt_q <= 16'h0001;
		end else if (!conv_done) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// result and busy decision at the end of conversion
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			result_q <= 16'h0000;
			busy_q <= 1'b0;
		end else if (conv_done) begin
			result_q <= held_q;
			busy_q <= chain_q ? chain_busy_q : cs_busy;
		end
	end

	// output shift path; only falling clock edges move it, so each bit
	// stands across the following rising and falling edges
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			shift_q <= 17'h00000;
			falls_q <= 5'h00;
		end else if (conv_done) begin
			// start bit in the top, result below it
			shift_q <= {1'b0, held_q};
			falls_q <= 5'h00;
		end else if (state_q == adc_link_pkg::DEV_SHIFT && sck_fall) begin
			// chain feeds upstream data in at the bottom
			shift_q <= {shift_q[15:0], chain_q ? sdi_s : 1'b0};
			falls_q <= falls_q + 5'h01;
		end
	end

	// line drive: released during conversion and outside readout
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			oe_q <= 1'b0;
		end else begin
			case (state_q)
				adc_link_pkg::DEV_CONV: begin
					oe_q <= conv_done && (chain_q || cs_busy);
				end
				adc_link_pkg::DEV_WAIT: begin
					oe_q <= select_on && !cnv_rise;
				end
				adc_link_pkg::DEV_SHIFT: begin
					if (cnv_rise || read_last || (!chain_q && select_rise)) begin
						oe_q <= 1'b0;
					end else if (chain_q && cnv_fall) begin
						oe_q <= 1'b0;
					end
				end
				default: begin
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	// =====================================================
	// outputs; the start bit in bit 16 goes out only when busy is on
	assign link.serial_result_out = busy_q ? shift_q[16] : shift_q[15];
	assign link.serial_result_oe = oe_q;
	assign converting = (state_q == adc_link_pkg::DEV_CONV);
	assign low_power = (state_q != adc_link_pkg::DEV_CONV);
	assign chain_mode = chain_q;
	assign busy_enabled = busy_q;
	assign result = result_q;

endmodule // adc_device_end

// file: include/adc_link_pkg.sv
// constants shared by both ends of the converter serial link
// assumes a 200 MHz system clock on each end
package adc_link_pkg;

	// =====================================================
	// result format
	localparam int RESULT_BITS = 16;
	localparam int START_BITS = RESULT_BITS + 1; // start bit plus result
	localparam logic [15:0] CODE_POS_FULL = 16'h7FFF; // overrange code
	localparam logic [15:0] CODE_NEG_FULL = 16'h8000; // underrange code

	// =====================================================
	// timing; conversion window figures are plain defaults
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CONV_MIN_NS = 500;
	localparam int CONV_MAX_NS = 2200;
	// least time rounds up, longest time rounds down
	localparam int CONV_MIN_CYC = (CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONV_MAX_CYC = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [15:0] CONV_MIN_C16 = 16'(CONV_MIN_CYC);
	localparam logic [15:0] CONV_MAX_C16 = 16'(CONV_MAX_CYC);
	// host serial clock: half period in system cycles
	localparam logic [3:0] SCK_HALF_CYC = 4'h8;

	// =====================================================
	// host register map, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =====================================================
	// state machines
	typedef enum logic [3:0] {
		DEV_ACQ = 4'h1,
		DEV_CONV = 4'h2,
		DEV_WAIT = 4'h4,
		DEV_SHIFT = 4'h8
	} dev_state_t;

	typedef enum logic [3:0] {
		HOST_IDLE = 4'h1,
		HOST_CONV = 4'h2,
		HOST_LEAD = 4'h4,
		HOST_READ = 4'h8
	} host_state_t;

endpackage

// file: include/adc_link_if.sv
// serial link between converter and host, one modport for each
// the result line has a pull-up: it reads high when nobody drives it
interface adc_link_if;
	logic convert_start; // host drives, rising edge samples
	logic serial_data_in_select; // host drives, mode and read select
	logic serial_clock; // host drives
	logic serial_result_out; // device data bit
	logic serial_result_oe; // device drives the line while high
	logic serial_result_level; // resolved line level

	// pull-up stands in for the released line
	assign serial_result_level = serial_result_oe ? serial_result_out : 1'b1;

	modport device (
		input convert_start,
		input serial_data_in_select,
		input serial_clock,
		output serial_result_out,
		output serial_result_oe
	);

	modport host (
		output convert_start,
		output serial_data_in_select,
		output serial_clock,
		input serial_result_level
	);
endinterface

// file: rtl/adc_host_end.sv
// host end: three-wire chip-select reader behind an AXI4-Lite slave
// assumes the converter end of adc_link_if and a 200 MHz clock
module adc_host_end (
	// system
	input wire logic clk_sys,
	input wire logic resetn,
	// serial link
	adc_link_if.host link,
	// AXI4-Lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// =====================================================
	// register slave
	logic aw_got_q; // write address held
	logic w_got_q; // write data held
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_lane0_q; // byte lane 0 written
	logic wr_fire; // both halves present, response free
	logic start_pulse; // software asked for a conversion
	logic done_clr; // software clears the done flag

	assign s_axi_awready = ~aw_got_q;
	assign s_axi_wready = ~w_got_q;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
	assign start_pulse = wr_fire & w_lane0_q & (aw_addr_q == adc_link_pkg::REG_CTRL)
		& w_data_q[adc_link_pkg::CTRL_START_BIT];
	assign done_clr = wr_fire & w_lane0_q & (aw_addr_q == adc_link_pkg::REG_STATUS)
		& w_data_q[adc_link_pkg::STAT_DONE_BIT];

	// address and data taken in either order, held until the write fires
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h00000000;
			w_lane0_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_got_q) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_got_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_got_q) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_lane0_q <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_got_q <= 1'b0;
			end
		end
	end

	// write response; addresses other than control and status answer with an error
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= adc_link_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q == adc_link_pkg::REG_CTRL ||
				aw_addr_q == adc_link_pkg::REG_STATUS) ? adc_link_pkg::RESP_OKAY
				: adc_link_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// =====================================================
	// link sequencer
	adc_link_pkg::host_state_t state_q;
	logic [15:0] wait_q; // cycles since the start edge
	logic [3:0] div_q; // serial clock half-period divider
	logic sck_q; // serial clock out
	logic cnv_q; // convert out
	logic [4:0] bits_q; // bits sampled so far
	logic [15:0] data_q; // incoming result
	logic done_q; // sticky result-ready flag
	logic [1:0] sdo_sync_q; // result line synchroniser
	logic half_end; // divider at the end of a half period

	assign half_end = (div_q == adc_link_pkg::SCK_HALF_CYC - 4'h1);

	// result line passes two flops before use
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sdo_sync_q <= 2'h3;
		end else begin
			sdo_sync_q <= {sdo_sync_q[0], link.serial_result_level};
		end
	end

	// start, timed wait, convert low, then 16 clock periods
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= adc_link_pkg::HOST_IDLE;
			wait_q <= 16'h0000;
			div_q <= 4'h0;
			sck_q <= 1'b0;
			cnv_q <= 1'b0;
			bits_q <= 5'h00;
			data_q <= 16'h0000;
		end else begin
			case (state_q)
				adc_link_pkg::HOST_IDLE: begin
					div_q <= 4'h0;
					if (start_pulse) begin
						cnv_q <= 1'b1; // starts a conversion
						wait_q <= 16'h0000;
						state_q <= adc_link_pkg::HOST_CONV;
					end
				end
				adc_link_pkg::HOST_CONV: begin
					// no busy bit in use: time out the longest conversion
					// and keep convert high throughout
					wait_q <= wait_q + 16'h0001;
					if (wait_q >= adc_link_pkg::CONV_MAX_C16) begin
						cnv_q <= 1'b0; // selects the read
						state_q <= adc_link_pkg::HOST_LEAD;
					end
				end
				adc_link_pkg::HOST_LEAD: begin
					// let the MSB settle before the first clock
					div_q <= half_end ? 4'h0 : div_q + 4'h1;
					if (half_end) begin
						sck_q <= 1'b1;
						bits_q <= 5'h00;
						state_q <= adc_link_pkg::HOST_READ;
					end
				end
				adc_link_pkg::HOST_READ: begin
					div_q <= half_end ? 4'h0 : div_q + 4'h1;
					if (half_end && sck_q) begin
						// sample late in the high phase, then fall
						data_q <= {data_q[14:0], sdo_sync_q[1]};
						bits_q <= bits_q + 5'h01;
						sck_q <= 1'b0;
					end else if (half_end) begin
						if (bits_q == 5'(adc_link_pkg::RESULT_BITS)) begin
							// convert stays low here: a rise would start a conversion
							// nobody asked for, on a stale sample
							state_q <= adc_link_pkg::HOST_IDLE;
						end else begin
							sck_q <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= adc_link_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// done flag: a finishing read wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else if (state_q == adc_link_pkg::HOST_READ && half_end && !sck_q &&
			bits_q == 5'(adc_link_pkg::RESULT_BITS)) begin
			done_q <= 1'b1;
		end else if (done_clr || start_pulse) begin
			done_q <= 1'b0;
		end
	end

	// read channel
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= adc_link_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= adc_link_pkg::RESP_OKAY;
			case (s_axi_araddr)
				adc_link_pkg::REG_CTRL: s_axi_rdata <= 32'h00000000;
				adc_link_pkg::REG_STATUS: s_axi_rdata <= {30'h00000000, done_q,
					state_q != adc_link_pkg::HOST_IDLE};
				adc_link_pkg::REG_DATA: s_axi_rdata <= {16'h0000, data_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= adc_link_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// three-wire form: data-in held high, chip-select mode every time
	assign link.serial_data_in_select = 1'b1;
	assign link.convert_start = cnv_q;
	assign link.serial_clock = sck_q;

endmodule // adc_host_end

// file: bench/adc_conversion_serial_readout_checker.sv
// link checker for the first host-to-converter link
// assumes one clock domain and the plain link signals as inputs
module adc_conversion_serial_readout_checker (
	// system
	input wire logic clk_sys,
	input wire logic resetn,
	// link
	input wire logic convert_start,
	input wire logic serial_data_in_select,
	input wire logic serial_clock,
	input wire logic serial_result_oe,
	input wire logic serial_result_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// helpers
	logic [15:0] hi_q; // cycles convert has stood high
	logic [4:0] fall_q; // serial clock falls since select

	// high-time counter, cleared while convert is low
	always_ff @(posedge clk_sys) begin
		if (!resetn || !convert_start) begin
			hi_q <= 16'h0;
		end else begin
			hi_q <= hi_q + 16'h1;
		end
	end

	// fall counter, cleared while convert is high
	always_ff @(posedge clk_sys) begin
		if (!resetn || convert_start) begin
			fall_q <= 5'h0;
		end else if ($fell(serial_clock)) begin
			fall_q <= fall_q + 5'h1;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// =========================================
	// properties
	property p_rise_release;
		$rose(convert_start) |-> ##[0:6] !serial_result_oe;
	endproperty
	a_rise_release: assert property (p_rise_release)
		else $error("line not released after start");
	property p_conv_quiet;
		$rose(convert_start) |-> ##6 (!serial_result_oe) [*8];
	endproperty
	a_conv_quiet: assert property (p_conv_quiet)
		else $error("line driven during conversion");
	// a short drop is a restart pulse, not an early read
	property p_wait_max;
		$fell(convert_start) |-> hi_q >= adc_link_pkg::CONV_MAX_C16 || hi_q < 16'h4;
	endproperty
	a_wait_max: assert property (p_wait_max)
		else $error("read began before longest conversion");
	property p_msb_out;
		$fell(convert_start) && hi_q >= adc_link_pkg::CONV_MAX_C16 |-> ##[1:8] serial_result_oe;
	endproperty
	a_msb_out: assert property (p_msb_out)
		else $error("first bit not driven after select");
	property p_bit_hold;
		$rose(serial_clock) |-> ##1 $stable(serial_result_level) [*7];
	endproperty
	a_bit_hold: assert property (p_bit_hold)
		else $error("bit moved in clock high phase");
	property p_next_bit;
		$fell(serial_clock) && fall_q < 5'hF |-> ##6 serial_result_oe;
	endproperty
	a_next_bit: assert property (p_next_bit)
		else $error("line dropped before last bit");
	property p_last_release;
		$fell(serial_clock) && fall_q == 5'hF |-> ##[1:6] !serial_result_oe;
	endproperty
	a_last_release: assert property (p_last_release)
		else $error("line not released after last fall");
	property p_clk_phase;
		$rose(serial_clock) |-> serial_clock [*8] ##1 !serial_clock;
	endproperty
	a_clk_phase: assert property (p_clk_phase)
		else $error("serial clock high phase wrong");
	property p_three_wire;
		serial_data_in_select and (serial_clock |-> !convert_start);
	endproperty
	a_three_wire: assert property (p_three_wire)
		else $error("three-wire select or clock misused");

	// =========================================
	// coverage of the main traffic
	c_start: cover property ($rose(convert_start));
	c_msb: cover property ($fell(convert_start) ##[1:8] serial_result_oe);
	c_last: cover property ($fell(serial_clock) && fall_q == 5'hF);
endmodule // adc_conversion_serial_readout_checker

// file: bench/test_adc_conversion_serial_readout.sv
// self-checking bench: host end and converter end face each other
// assumes both design ends; a second link to a converter is bench-driven
module test_adc_conversion_serial_readout;
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// signals
	logic clk_sys, resetn, over, under, converting, low_power, chain2, busy2;
	logic [15:0] sample, conv_len, exp16;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd_last, tmp;
	logic [31:0] seed = 32'h30; // xorshift state
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [34:0] rq[$]; // read notes: check flag, resp, data
	logic [1:0] bq[$]; // write notes: resp
	logic [34:0] note;
	logic [5:0] cases [5] = '{6'h02, 6'h13, 6'h0A, 6'h20, 6'h25};
	int fail_count = 0;
	int n_tests = 0;
	adc_link_if link();
	adc_link_if link2(); // bench stands in for the host here

	// =========================================
	// design and checker
	adc_device_end adc_device_end_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link),
		.sample_value(sample), .over_range(over), .under_range(under), .conv_cycles(conv_len),
		.converting(converting), .low_power(low_power), .chain_mode(), .busy_enabled(),
		.result());
	adc_device_end adc_device_end_inst2 (.clk_sys(clk_sys), .resetn(resetn), .link(link2),
		.sample_value(sample), .over_range(over), .under_range(under), .conv_cycles(conv_len),
		.converting(), .low_power(), .chain_mode(chain2), .busy_enabled(busy2), .result());
	adc_host_end adc_host_end_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	adc_conversion_serial_readout_checker adc_conversion_serial_readout_checker_inst (
		.clk_sys(clk_sys), .resetn(resetn), .convert_start(link.convert_start),
		.serial_data_in_select(link.serial_data_in_select), .serial_clock(link.serial_clock),
		.serial_result_oe(link.serial_result_oe),
		.serial_result_level(link.serial_result_level));

	// =========================================
	// helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// one comparison, counted
	task automatic check(input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	// single closing point of the run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// write: both channels offered together, each released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w, fa, fw;
		bq.push_back(r);
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			// readies only move at rising edges, so mid-cycle is safe
			@(negedge clk_sys);
			fa = aw && awready;
			fw = w && wready;
			@(posedge clk_sys);
			if (fa) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (fw) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		do @(negedge clk_sys); while (!bvalid);
		@(posedge clk_sys);
		bready <= 1'b0;
	endtask

	// read: note first, then address, then wait for the answer
	task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic c);
		rq.push_back({c, e});
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk_sys); while (!arready);
		@(posedge clk_sys);
		arvalid <= 1'b0;
		do @(negedge clk_sys); while (!rvalid);
		@(posedge clk_sys);
		// data taken at the edge where rvalid and rready meet
		rd_last = rdata;
		rready <= 1'b0;
	endtask

	// second converter: mode pick and busy pick from the wire levels
	task automatic dev2(input logic [5:0] c);
		@(posedge clk_sys);
		link2.convert_start <= 1'b0;
		link2.serial_data_in_select <= c[5];
		link2.serial_clock <= c[4];
		repeat (10) @(posedge clk_sys);
		link2.convert_start <= 1'b1;
		if (c[3]) begin
			link2.serial_data_in_select <= 1'b1; // data-in wired to convert
		end
		if (c[2]) begin
			repeat (20) @(posedge clk_sys);
			link2.convert_start <= 1'b0; // still low when conversion ends
		end
		repeat (150) @(posedge clk_sys);
	endtask

	// =========================================
	// response monitor: oldest note against each answer
	always @(posedge clk_sys) begin
		if (rvalid && rready && rq.size() > 0) begin
			note = rq.pop_front();
			if (note[34]) begin
				check(note[33:0], {rresp, rdata});
			end
		end
		if (bvalid && bready && bq.size() > 0) begin
			check({bq.pop_front(), 32'h0}, {bresp, 32'h0});
		end
	end

	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#100us;
		fail_count++;
		wrap_up();
	end

	// =========================================
	// main sequence
	initial begin
		resetn = 1'b0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		{sample, over, under} = '0;
		conv_len = 16'h64;
		link2.convert_start = 1'b0;
		link2.serial_data_in_select = 1'b1;
		link2.serial_clock = 1'b0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		// reset values and unmapped places
		rd(adc_link_pkg::REG_STATUS, 34'h0, 1'b1);
		rd(adc_link_pkg::REG_CTRL, 34'h0, 1'b1);
		rd(adc_link_pkg::REG_DATA, 34'h0, 1'b1);
		rd(4'hC, {adc_link_pkg::RESP_SLVERR, 32'h0}, 1'b1);
		wr(4'hC, 32'h1, adc_link_pkg::RESP_SLVERR);
		// conversions: range codes first, then random samples and lengths
		for (int i = 0; i < 6; i++) begin
			tmp = xs();
			exp16 = (i == 0 || i == 2) ? adc_link_pkg::CODE_POS_FULL :
				(i == 1) ? adc_link_pkg::CODE_NEG_FULL : tmp[15:0];
			@(posedge clk_sys);
			sample <= tmp[15:0];
			over <= (i == 0 || i == 2);
			under <= (i == 1 || i == 2);
			conv_len <= 16'h64 + 16'(tmp[31:16] % 16'h14A);
			wr(adc_link_pkg::REG_CTRL, 32'h1, adc_link_pkg::RESP_OKAY);
			repeat (20) @(posedge clk_sys);
			check(34'({converting, low_power}), 34'h2);
			rd(adc_link_pkg::REG_STATUS, 34'h1, 1'b1);
			do rd(adc_link_pkg::REG_STATUS, 34'h0, 1'b0); while (!rd_last[1]);
			check(34'({converting, low_power}), 34'h1);
			rd(adc_link_pkg::REG_DATA, {18'h0, exp16}, 1'b1);
			wr(adc_link_pkg::REG_STATUS, 32'h2, adc_link_pkg::RESP_OKAY);
			rd(adc_link_pkg::REG_STATUS, 34'h0, 1'b1);
		end
		// second converter: data-in, clock and wiring pick mode and busy
		conv_len <= 16'h64;
		for (int i = 0; i < 5; i++) begin
			dev2(cases[i]);
			check(34'({chain2, busy2}), 34'(cases[i][1:0]));
			// busy shows the start bit, chain shows the MSB, plain select stays released
			if (cases[i][0]) begin
				check(34'(link2.serial_result_level), 34'h0);
			end else if (cases[i][1]) begin
				check(34'(link2.serial_result_level), 34'(sample[15]));
			end else begin
				check(34'(link2.serial_result_level), 34'h1);
			end
		end
		wrap_up();
	end
endmodule // test_adc_conversion_serial_readout
